// ===== design/scm_pkg.sv
// package: register map, field positions and pin carrier for the spi client block
package scm_pkg;
  // register indices; byte address is four times the index
  localparam logic [2:0] SCM_IDX_CTRL_FIRST  = 3'h0;
  localparam logic [2:0] SCM_IDX_CTRL_SECOND = 3'h1;
  localparam logic [2:0] SCM_IDX_INT_CTRL    = 3'h2;
  localparam logic [2:0] SCM_IDX_INT_FLAG    = 3'h3;
  localparam logic [2:0] SCM_IDX_DATA        = 3'h4;
  localparam logic [2:0] SCM_IDX_PIN_CFG     = 3'h5;
  localparam logic [2:0] SCM_IDX_LAST        = 3'h5;

  // control_first_reg fields
  localparam int SCM_BIT_ENABLE       = 0;
  localparam int SCM_BIT_HOST         = 5;
  localparam int SCM_BIT_ORDER        = 6;
  // control_second_reg fields
  localparam int SCM_BIT_SEL_IGNORE   = 2;
  localparam int SCM_BIT_WAIT_RX      = 6;
  localparam int SCM_BIT_BUF_ON       = 7;
  // interrupt control fields
  localparam int SCM_BIT_IE           = 0;
  localparam int SCM_BIT_DREIE        = 5;
  localparam int SCM_BIT_TXCIE        = 6;
  localparam int SCM_BIT_RXCIE        = 7;
  // interrupt_flag_reg fields, normal view and buffered view
  localparam int SCM_BIT_DONE         = 7;
  localparam int SCM_BIT_WCOL         = 6;
  localparam int SCM_BIT_RXC          = 7;
  localparam int SCM_BIT_TXC          = 6;
  localparam int SCM_BIT_DRE          = 5;
  // pin configuration fields
  localparam int SCM_BIT_SEL_DIR_OUT  = 0;
  localparam int SCM_BIT_MISO_DIR_OUT = 1;

  // reset values and bits per byte
  localparam logic [7:0] SCM_RST_CTRL     = 8'h00;
  localparam logic [7:0] SCM_RST_SHIFT    = 8'h00;
  localparam logic [3:0] SCM_BITS_PER_BYTE = 4'h8;

  // pins from the serial side, carried together
  typedef struct packed {
    logic sck;
    logic mosi;
    logic sel_n;
  } scm_pins_t;

  // idle pin levels; select starts released so no false select follows reset
  localparam scm_pins_t SCM_RST_PINS = '{sck: 1'b0, mosi: 1'b0, sel_n: 1'b1};
endpackage

// ===== design/scm_sync.sv
// three-stage input synchroniser with agreement filter for the serial pins
`timescale 1ns/1ps
`default_nettype none
module scm_sync
  import scm_pkg::*;
(
  input  wire logic      pclk,
  input  wire logic      presetn,
  input  wire scm_pins_t pins_in,
  output var scm_pins_t  pins_out
);
  localparam int W = $bits(scm_pins_t);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] out_r;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_r[i]  <= SCM_RST_PINS[i];
          s2_r[i]  <= SCM_RST_PINS[i];
          s3_r[i]  <= SCM_RST_PINS[i];
          out_r[i] <= SCM_RST_PINS[i];
        end else begin
          s1_r[i] <= pins_in[i];
          s2_r[i] <= s1_r[i];
          s3_r[i] <= s2_r[i];
          // first stage feeds only the second
          if (s2_r[i] == s3_r[i]) begin
            out_r[i] <= s3_r[i];
          end
        end
      end
    end
  endgenerate

  assign pins_out = out_r;
endmodule // scm_sync
`default_nettype wire

// ===== design/scm_spi_client.sv
// spi client shift logic, buffered modes and host select arbitration behind apb
//
// Contract
// - low select input drops host into client
// - forced drop sets transfer-done flag
// - select as output never disturbs host
// - ignore bit set: select pin unused as host
// - idle while select high, no shifting
// - normal mode: flag after each byte
// - busy write dropped, collision flag set
// - received byte kept apart from load
// - select high aborts byte and counter
// - buffer bit selects buffered client modes
// - no wait: writes buffered, dummy first
// - empty flag: clear on write, set on move
// - write while buffer full is dropped
// - receive flag one cycle after empty
// - all-sent flag follows when nothing left
// - wait mode: idle write reaches shifter
// - miso driven only when selected, output
// - bit order bit picks msb or lsb
// - irq while enabled flag stays set
`timescale 1ns/1ps
`default_nettype none
module scm_spi_client
  import scm_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sck_in,
  input  wire logic        mosi_in,
  input  wire logic        sel_n_in,
  output logic             miso_out,
  output logic             miso_oe,
  output logic             irq
);
  typedef enum logic [2:0] {
    SCM_ST_IDLE  = 3'b001,
    SCM_ST_SHIFT = 3'b010,
    SCM_ST_DONE  = 3'b100
  } scm_state_t;

  scm_pins_t   pins_raw;
  scm_pins_t   pins;
  scm_state_t  state_r;
  logic        sck_prev_r;
  logic        sck_rise;
  logic        sck_fall;
  logic [3:0]  cnt_r;
  logic        bit_r;
  logic [7:0]  shift_r;
  logic [7:0]  rx_r;
  logic [7:0]  tx_buf_r;
  logic        dre_r;
  logic        sr_loaded_r;
  logic        done_r;
  logic        done_d_r;
  logic        done_if_r;
  logic        wcol_r;
  logic        rxc_r;
  logic        txc_r;
  logic [7:0]  ctrl_a_r;
  logic [7:0]  ctrl_b_r;
  logic [7:0]  int_ctrl_r;
  logic [1:0]  pin_cfg_r;
  logic [31:0] prdata_r;
  logic        pslverr_r;
  logic        miso_r;
  logic [2:0]  idx;
  logic        addr_ok;
  logic        wr_acc;
  logic        wr_data;
  logic        wr_flag;
  logic        enabled;
  logic        host;
  logic        buf_on;
  logic        selected;
  logic        busy;
  logic        byte_done;
  logic        force_client;
  logic        wait_load;
  logic [7:0]  flag_view;
  logic [7:0]  shift_in;

  assign pins_raw = '{sck: sck_in, mosi: mosi_in, sel_n: sel_n_in};

  scm_sync u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .pins_in  (pins_raw),
    .pins_out (pins)
  );

  // ---- apb decode ----
  assign idx     = paddr[4:2];
  assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[7:5] == 3'h0) && (idx <= SCM_IDX_LAST);
  assign wr_acc  = psel && penable && pwrite && addr_ok;
  assign wr_data = wr_acc && (idx == SCM_IDX_DATA);
  assign wr_flag = wr_acc && (idx == SCM_IDX_INT_FLAG);
  // answer always at the first access cycle; read data is captured in setup
  assign pready  = 1'b1;
  assign prdata  = prdata_r;
  assign pslverr = pslverr_r;

  assign enabled  = ctrl_a_r[SCM_BIT_ENABLE];
  assign host     = ctrl_a_r[SCM_BIT_HOST];
  assign buf_on   = ctrl_b_r[SCM_BIT_BUF_ON];
  // select is always an input in client mode
  assign selected = enabled && !host && !pins.sel_n;
  assign busy     = selected && (cnt_r != 4'h0);

  // select low on an input pin, not ignored, pulls host down
  assign force_client = enabled && host && !ctrl_b_r[SCM_BIT_SEL_IGNORE]
                        && !pin_cfg_r[SCM_BIT_SEL_DIR_OUT] && !pins.sel_n;

  // first idle write in wait mode moves from the buffer to the shifter one cycle later
  assign wait_load = buf_on && ctrl_b_r[SCM_BIT_WAIT_RX] && !dre_r && !sr_loaded_r
                     && !selected && enabled && !host;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_a_r   <= SCM_RST_CTRL;
      ctrl_b_r   <= SCM_RST_CTRL;
      int_ctrl_r <= SCM_RST_CTRL;
      pin_cfg_r  <= 2'h0;
    end else begin
      if (wr_acc && idx == SCM_IDX_CTRL_FIRST) begin
        ctrl_a_r <= pwdata[7:0];
      end
      if (force_client) begin
        ctrl_a_r[SCM_BIT_HOST] <= 1'b0; // hardware clear wins over a write
      end
      if (wr_acc && idx == SCM_IDX_CTRL_SECOND) begin
        ctrl_b_r <= pwdata[7:0];
      end
      if (wr_acc && idx == SCM_IDX_INT_CTRL) begin
        int_ctrl_r <= pwdata[7:0];
      end
      if (wr_acc && idx == SCM_IDX_PIN_CFG) begin
        pin_cfg_r <= pwdata[1:0];
      end
    end
  end

  // ---- sck edge detection on the filtered copy ----
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_prev_r <= 1'b0;
    end else begin
      sck_prev_r <= pins.sck;
    end
  end
  assign sck_rise = pins.sck && !sck_prev_r;
  assign sck_fall = !pins.sck && sck_prev_r;

  // ---- bit state machine ----
  // sample on rising sck, shift on falling; only phase/polarity zero is served
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= SCM_ST_IDLE;
      cnt_r   <= 4'h0;
      bit_r   <= 1'b0;
    end else if (!selected) begin
      state_r <= SCM_ST_IDLE; // select high aborts at once
      cnt_r   <= 4'h0;
      bit_r   <= 1'b0;
    end else begin
      case (state_r)
        SCM_ST_IDLE: begin
          if (sck_rise) begin
            bit_r   <= pins.mosi;
            cnt_r   <= 4'h1;
            state_r <= SCM_ST_SHIFT;
          end
        end
        SCM_ST_SHIFT: begin
          if (sck_rise) begin
            bit_r <= pins.mosi;
            cnt_r <= cnt_r + 4'h1;
          end else if (sck_fall && cnt_r == SCM_BITS_PER_BYTE) begin
            state_r <= SCM_ST_DONE;
          end
        end
        SCM_ST_DONE: begin
          cnt_r   <= 4'h0;
          state_r <= SCM_ST_IDLE;
        end
        default: begin
          state_r <= SCM_ST_IDLE;
          cnt_r   <= 4'h0;
        end
      endcase
    end
  end

  assign byte_done = selected && (state_r == SCM_ST_DONE);
  assign shift_in  = ctrl_a_r[SCM_BIT_ORDER] ? {bit_r, shift_r[7:1]} : {shift_r[6:0], bit_r};

  // ---- shift register, receive register, transmit buffer ----
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_r     <= SCM_RST_SHIFT;
      rx_r        <= SCM_RST_SHIFT;
      tx_buf_r    <= SCM_RST_SHIFT;
      dre_r       <= 1'b1;
      sr_loaded_r <= 1'b0;
    end else begin
      if (selected && state_r == SCM_ST_SHIFT && sck_fall) begin
        shift_r <= shift_in;
      end
      if (byte_done) begin
        rx_r <= shift_r; // separate from tx loads
      end
      if (buf_on) begin
        if (byte_done) begin
          if (!dre_r) begin
            shift_r     <= tx_buf_r; // buffered byte moves
            dre_r       <= 1'b1;
            sr_loaded_r <= 1'b1;
          end else begin
            sr_loaded_r <= 1'b0;
          end
        end else if (wait_load) begin
          shift_r     <= tx_buf_r;
          dre_r       <= 1'b1;
          sr_loaded_r <= 1'b1;
        end
        // full buffer drops the write a write clears empty
        if (wr_data && dre_r && !byte_done && !wait_load) begin
          tx_buf_r <= pwdata[7:0];
          dre_r    <= 1'b0;
        end
      end else begin
        dre_r <= 1'b1;
        // busy write leaves the shifter alone
        if (wr_data && !busy && !byte_done) begin
          shift_r     <= pwdata[7:0];
          sr_loaded_r <= 1'b1;
        end
      end
    end
  end

  // ---- flags; a set in the cycle of a clear wins ----
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_r    <= 1'b0;
      done_d_r  <= 1'b0;
      done_if_r <= 1'b0;
      wcol_r    <= 1'b0;
      rxc_r     <= 1'b0;
      txc_r     <= 1'b0;
    end else begin
      done_r   <= buf_on && byte_done; // lines up with the empty flag rising
      done_d_r <= done_r;
      if (wr_flag && pwdata[SCM_BIT_DONE] && !buf_on) begin
        done_if_r <= 1'b0;
      end
      if ((byte_done && !buf_on) || force_client) begin
        done_if_r <= 1'b1;
      end
      if (wr_flag && pwdata[SCM_BIT_WCOL] && !buf_on) begin
        wcol_r <= 1'b0;
      end
      if (wr_data && !buf_on && (busy || byte_done)) begin
        wcol_r <= 1'b1;
      end
      if (wr_flag && pwdata[SCM_BIT_RXC] && buf_on) begin
        rxc_r <= 1'b0;
      end
      if (done_r) begin
        rxc_r <= 1'b1;
      end
      if (wr_flag && pwdata[SCM_BIT_TXC] && buf_on) begin
        txc_r <= 1'b0;
      end
      if (done_d_r && dre_r && !sr_loaded_r) begin
        txc_r <= 1'b1;
      end
    end
  end

  assign flag_view = buf_on ? {rxc_r, txc_r, dre_r, 5'h00} : {done_if_r, wcol_r, 6'h00};

  // interrupt stays up until the flag is cleared
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else if (buf_on) begin
      irq <= (rxc_r && int_ctrl_r[SCM_BIT_RXCIE]) || (txc_r && int_ctrl_r[SCM_BIT_TXCIE])
             || (dre_r && int_ctrl_r[SCM_BIT_DREIE]);
    end else begin
      irq <= (done_if_r || wcol_r) && int_ctrl_r[SCM_BIT_IE];
    end
  end

  // ---- miso: registered bit, driven only while selected and port is output ----
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      miso_r <= 1'b0;
    end else begin
      miso_r <= ctrl_a_r[SCM_BIT_ORDER] ? shift_r[0] : shift_r[7];
    end
  end
  assign miso_out = miso_r;
  assign miso_oe  = selected && pin_cfg_r[SCM_BIT_MISO_DIR_OUT];

  // ---- apb read data, captured in the setup cycle ----
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (psel && !penable) begin
      pslverr_r <= !addr_ok;
      case (idx)
        SCM_IDX_CTRL_FIRST:  prdata_r <= {24'h000000, ctrl_a_r};
        SCM_IDX_CTRL_SECOND: prdata_r <= {24'h000000, ctrl_b_r};
        SCM_IDX_INT_CTRL:    prdata_r <= {24'h000000, int_ctrl_r};
        SCM_IDX_INT_FLAG:    prdata_r <= {24'h000000, flag_view};
        SCM_IDX_DATA:        prdata_r <= {24'h000000, rx_r};
        SCM_IDX_PIN_CFG:     prdata_r <= {30'h0, pin_cfg_r};
        default:             prdata_r <= 32'h0000_0000;
      endcase
      if (!addr_ok) begin
        prdata_r <= 32'h0000_0000;
      end
    end
  end
endmodule // scm_spi_client
`default_nettype wire

// ===== tb/scm_spi_client_asserts.sv
// port checker for the spi client block
`timescale 1ns/1ps
`default_nettype none
module scm_spi_client_asserts
  import scm_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sck_in,
  input wire logic        mosi_in,
  input wire logic        sel_n_in,
  input wire logic        miso_out,
  input wire logic        miso_oe,
  input wire logic        irq
);
  logic ie_r;
  wire  bad_addr = paddr[7:5] != 3'h0 || paddr[1:0] != 2'h0 || paddr[4:2] > SCM_IDX_LAST;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // any interrupt source enabled, as last written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ie_r <= 1'b0;
    else if (psel && penable && pwrite && paddr == 8'h08)
      ie_r <= pwdata[7:0] != 8'h00;
  end
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable;
  endsequence
  // six samples cover the three flops plus the agreement filter
  sequence desel_s;
    sel_n_in [*6];
  endsequence
  chk_ready_high: assert property (pready) else $error("pready low");
  chk_bad_refused: assert property (setup_s ##0 bad_addr |=> access_s ##0 (pslverr && prdata == 32'h0))
    else $error("bad address not refused");
  chk_good_accepted: assert property (setup_s ##0 !bad_addr |=> !pslverr) else $error("good address refused");
  chk_upper_zero: assert property (access_s |-> prdata[31:8] == 24'h0) else $error("prdata upper bits set");
  chk_oe_deselect: assert property (desel_s |-> !miso_oe) else $error("miso driven while deselected");
  chk_oe_selected: assert property (miso_oe |-> !$past(sel_n_in, 2) || !$past(sel_n_in, 3) ||
    !$past(sel_n_in, 4) || !$past(sel_n_in, 5)) else $error("miso driven without select");
  chk_irq_masked: assert property (access_s ##0 (pwrite && paddr == 8'h08 && pwdata[7:0] == 8'h00)
    |=> ##1 !irq) else $error("irq stays with sources off");
  chk_irq_cause: assert property (irq |-> ie_r || $past(ie_r)) else $error("irq with no source enabled");
endmodule // scm_spi_client_asserts
bind scm_spi_client scm_spi_client_asserts u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sck_in(sck_in), .mosi_in(mosi_in), .sel_n_in(sel_n_in), .miso_out(miso_out),
  .miso_oe(miso_oe), .irq(irq));
`default_nettype wire

// ===== tb/scm_host_model.sv
// behavioural spi host, mode 0, facing the client block
`timescale 1ns/1ps
`default_nettype none
module scm_host_model (
  output var logic       sck,
  output var logic       mosi,
  output var logic       sel_n,
  input  wire logic      miso,
  output var logic [7:0] rx_byte,
  output var logic       rx_stb
);
  initial begin
    sck = 1'b0;
    mosi = 1'b0;
    sel_n = 1'b1;
    rx_byte = 8'h00;
    rx_stb = 1'b0;
  end
  // pins move off the pclk edge so the sampling order is fixed
  task automatic hold(input bit v);
    #13 sel_n = v;
  endtask
  // 200 ns phases keep each level well over two pclk
  task automatic frame(input logic [7:0] d, input int n, input bit lsb, input bit sel);
    int k;
    logic [7:0] r;
    r = 8'h00;
    #13 sel_n = !sel;
    #400;
    for (int i = 0; i < n; i++) begin
      k = lsb ? i : 7 - i;
      mosi = d[k];
      #200 sck = 1'b1;
      // miso sampled late in the phase: client output lags the pin by pclk cycles
      #190 r[k] = miso;
      #10 sck = 1'b0;
    end
    mosi = ~mosi;
    #400 sel_n = 1'b1;
    #400;
    if (n == 8) begin
      rx_byte = r;
      rx_stb = 1'b1;
      #10 rx_stb = 1'b0;
    end
  endtask
endmodule // scm_host_model
`default_nettype wire

// ===== tb/tb_top.sv
// self-checking testbench for the spi client block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, e;
  logic        pready, pslverr, miso_out, miso_oe, irq;
  logic        sck, mosi, sel_n, rx_stb;
  logic [7:0]  rx_byte;
  logic [7:0]  v [16];
  logic [31:0] rd_q [$];
  logic [7:0]  spi_q [$];
  int          fails, compares, cyc;
  wire         miso_w;
  assign miso_w = miso_oe ? miso_out : 1'bz;
  always #25 pclk = ~pclk;
  scm_spi_client dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sck_in(sck),
    .mosi_in(mosi), .sel_n_in(sel_n), .miso_out(miso_out), .miso_oe(miso_oe), .irq(irq));
  scm_host_model host (.sck(sck), .mosi(mosi), .sel_n(sel_n), .miso(miso_w), .rx_byte(rx_byte),
    .rx_stb(rx_stb));
  task automatic cmp(input string n, input logic [31:0] x, input logic [31:0] g);
    compares++;
    if (g !== x) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", n, x, g);
    end
  endtask
  task automatic conclude;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic apb(input bit w, input logic [2:0] i, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {3'h0, i, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] i, input logic [7:0] x);
    rd_q.push_back({24'h0, x});
    apb(1'b0, i, 8'h00);
  endtask
  task automatic wr(input logic [2:0] i, input logic [7:0] d);
    apb(1'b1, i, d);
  endtask
  task automatic xfer(input logic [7:0] t, input logic [7:0] x, input bit lsb);
    spi_q.push_back(x);
    host.frame(t, 8, lsb, 1'b1);
  endtask
  task automatic irq_is(input logic x);
    repeat (3) @(posedge pclk);
    cmp("irq", {31'h0, x}, {31'h0, irq});
  endtask
  // read data taken at the edge that completes the access
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready === 1'b1) begin
      e = rd_q.pop_front();
      cmp("prdata", e, prdata);
    end
  end
  always @(posedge rx_stb) cmp("miso byte", {24'h0, spi_q.pop_front()}, {24'h0, rx_byte});
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 9000) begin
      fails++;
      conclude();
    end
  end
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    void'($urandom(32'h0A39));
    foreach (v[i]) v[i] = 8'($urandom);
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    rd(3'h0, 8'h00);
    rd(3'h6, 8'h00);
    wr(3'h7, 8'hFF);
    wr(3'h5, 8'h02);
    wr(3'h0, 8'h01);
    wr(3'h4, v[0]);
    host.frame(8'hA5, 7, 1'b0, 1'b0);
    xfer(v[1], v[0], 1'b0);
    wr(3'h4, v[2]);
    rd(3'h4, v[1]);
    rd(3'h3, 8'h80);
    wr(3'h3, 8'hFF);
    fork
      xfer(v[3], v[2], 1'b0);
      begin
        repeat (30) @(posedge pclk);
        wr(3'h4, ~v[2]);
      end
    join
    rd(3'h3, 8'hC0);
    wr(3'h3, 8'hFF);
    wr(3'h4, v[4]);
    host.frame(8'hFF, 3, 1'b0, 1'b1);
    rd(3'h3, 8'h00);
    rd(3'h4, v[3]);
    wr(3'h4, v[4]);
    xfer(v[5], v[4], 1'b0);
    rd(3'h4, v[5]);
    wr(3'h0, 8'h41);
    wr(3'h4, v[6]);
    xfer(v[7], v[6], 1'b1);
    rd(3'h4, v[7]);
    wr(3'h0, 8'h01);
    wr(3'h3, 8'hFF);
    wr(3'h1, 8'h80);
    rd(3'h3, 8'h20);
    wr(3'h4, v[7] ^ 8'h0F);
    rd(3'h3, 8'h00);
    wr(3'h4, v[7] ^ 8'hF0);
    xfer(v[9], v[7], 1'b0);
    rd(3'h3, 8'hA0);
    wr(3'h3, 8'h80);
    xfer(v[10], v[7] ^ 8'h0F, 1'b0);
    rd(3'h3, 8'hE0);
    wr(3'h3, 8'hFF);
    wr(3'h1, 8'hC0);
    wr(3'h4, v[11]);
    wr(3'h4, v[12]);
    xfer(v[13], v[11], 1'b0);
    xfer(v[14], v[12], 1'b0);
    wr(3'h2, 8'h80);
    irq_is(1'b1);
    wr(3'h3, 8'h80);
    irq_is(1'b0);
    wr(3'h2, 8'h40);
    irq_is(1'b1);
    wr(3'h2, 8'h20);
    irq_is(1'b1);
    wr(3'h2, 8'h00);
    irq_is(1'b0);
    wr(3'h1, 8'h04);
    wr(3'h3, 8'hFF);
    wr(3'h2, 8'h01);
    wr(3'h0, 8'h21);
    host.hold(1'b0);
    repeat (10) @(posedge pclk);
    rd(3'h0, 8'h21);
    host.hold(1'b1);
    repeat (10) @(posedge pclk);
    wr(3'h1, 8'h00);
    wr(3'h5, 8'h03);
    host.hold(1'b0);
    repeat (10) @(posedge pclk);
    rd(3'h0, 8'h21);
    wr(3'h5, 8'h02);
    repeat (10) @(posedge pclk);
    rd(3'h0, 8'h01);
    rd(3'h3, 8'h80);
    irq_is(1'b1);
    host.hold(1'b1);
    repeat (10) @(posedge pclk);
    rd(3'h0, 8'h01);
    wr(3'h0, 8'h21);
    rd(3'h0, 8'h21);
    conclude();
  end
endmodule // tb_top
`default_nettype wire
